//--- logic/ptc_pkg.sv
// Constants and types for the pump trigger and configuration block.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package ptc_pkg;

  typedef enum logic [3:0] {
    FALLING_TOGGLE, FALLING_START_RISING_STOP, RISING_TOGGLE,
    LEVEL_FOLLOW, FALLING_START_ONLY, RISING_START_ONLY,
    FALLING_STOP_ONLY, RISING_STOP_ONLY, RUN_ON_LOW, RUN_ON_HIGH,
    HALT_ON_LOW, HALT_ON_HIGH, TRIGGER_DISABLED, EDGE_RAISES_EVENT,
    KEY_RAISES_EVENT
  } ptc_trig_e;

  typedef enum logic [2:0] {
    BAUD_300, BAUD_1200, BAUD_2400, BAUD_9600, BAUD_19200
  } ptc_baud_e;

  typedef enum logic [1:0] {
    COMM_ADDRESS, COMM_OPPOSITE, COMM_TWIN, COMM_ALTERNATE
  } ptc_comm_e;

  // Register offsets
  localparam logic [3:0] REG_SETUP   = 4'h0;
  localparam logic [3:0] REG_NET     = 4'h1;
  localparam logic [3:0] REG_PRGTRIG = 4'h2;
  localparam logic [3:0] REG_STATUS  = 4'h3;
  localparam logic [3:0] REG_CMD     = 4'h4;

  // Setup register fields
  localparam int SETUP_TRIG_LSB = 0;
  localparam int SETUP_DIRTWIN  = 4;
  localparam int SETUP_OUTCFG   = 5;
  localparam int SETUP_ALARM    = 6;
  localparam int SETUP_BEEP     = 7;
  localparam int SETUP_LOCK     = 8;
  localparam int SETUP_LOWNOISE = 9;
  localparam int SETUP_COMM_LSB = 10;
  // Net register fields
  localparam int NET_ADDR_LSB   = 0;
  localparam int NET_BAUD_LSB   = 8;
  // Command register bits (write 1 pulses)
  localparam int CMD_RUN        = 0;
  localparam int CMD_STOP       = 1;
  localparam int CMD_CLR_EVENT  = 2;

  localparam ptc_trig_e RST_TRIG  = FALLING_TOGGLE;
  localparam ptc_baud_e RST_BAUD  = BAUD_19200;
  localparam logic [6:0] RST_ADDR = 7'h00;
  localparam logic [6:0] MAX_ADDR = 7'h63;

  // Debounce settle time
  localparam int DEBOUNCE_US = 5;
  localparam int CLK_MHZ     = 100;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int DB_W = $clog2(DEBOUNCE_CYC + 1);
  // Beep cadence: single beep length and continuous on/off half period
  localparam int BEEP_MS = 100;
  localparam int BEEP_CYC = BEEP_MS * 1000 * CLK_MHZ;
  localparam int BP_W = $clog2(BEEP_CYC + 1);

endpackage

//--- logic/ptc_trigger_config.sv
// Trigger decode, direction, motor output, lockout, buzzer and
// serial setup holding for the pump controller.
// Assumes inputs synchronous to clk; sequencer supplies program state.
`timescale 1ns/100ps
module ptc_trigger_config #(
  parameter int DEBOUNCE_CYC = ptc_pkg::DEBOUNCE_CYC,
  parameter int BEEP_CYC     = ptc_pkg::BEEP_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdData,
  // Link pins
  input  wire logic        trigIn,
  input  wire logic        dirIn,
  input  wire logic        lockKeyPresent_n,
  output logic             motorOperating,
  output logic             buzzer,
  // Keypad
  input  wire logic        keyPress,
  input  wire logic        keyStartStop,
  input  wire logic        keySetting,
  output logic             keySettingAllowed,
  // Sequencer side
  input  wire logic        motorPumping,
  input  wire logic        pauseTimer,
  input  wire logic        programEnded,
  input  wire logic        waitStartTrig,
  input  wire logic        alarmCond,
  input  wire logic        progTrigWrite,
  input  wire logic [3:0]  progTrigMode,
  output logic             runProgram,
  output logic             programEvent,
  output logic             dirWithdraw,
  // Secondary pump forwarding
  output logic             secRun,
  output logic             secWithdraw,
  output logic             secStartPulse
);

  typedef struct packed {
    logic [15:0]         rdData;
    logic [3:0]          trig;
    logic                dirTwin;
    logic                outCfg;
    logic                alarmEn;
    logic                beepEn;
    logic                lockEn;
    logic                lowNoise;
    ptc_pkg::ptc_comm_e  comm;
    logic [6:0]          addr;
    ptc_pkg::ptc_baud_e  baud;
    logic                trigSync1;
    logic                trigSync2;
    logic                trigStable;
    logic [15:0]         trigCnt;
    logic                dirSync1;
    logic                dirSync2;
    logic                dirStable;
    logic [15:0]         dirCnt;
    logic                run;
    logic                withdraw;
    logic                event_;
    logic                alarmLatched;
    logic                alarmSilenced;
    logic [31:0]         beepCnt;
    logic                beepSingle;
    logic                beepPhase;
    logic                secStart;
  } ptc_state_s;

  ptc_state_s st;
  ptc_state_s next_st;

  //////////////////////////////////////////////////////////////////////////
  logic trigFall;
  logic trigRise;
  logic dirFall;
  logic dirRise;
  logic wrSetup;
  logic wrNet;
  logic wrCmd;
  logic keyEventMode;

  always_comb begin
    logic startReq;
    logic stopReq;
    logic toggleReq;
    startReq  = 1'b0;
    stopReq   = 1'b0;
    toggleReq = 1'b0;
    next_st   = st;
    next_st.secStart = 1'b0;

    wrSetup = regWrite && regAddr == ptc_pkg::REG_SETUP;
    wrNet   = regWrite && regAddr == ptc_pkg::REG_NET;
    wrCmd   = regWrite && regAddr == ptc_pkg::REG_CMD;

    // Two-flop sync, then a hold-off counter filters contact bounce
    next_st.trigSync1 = trigIn;
    next_st.trigSync2 = st.trigSync1;
    next_st.dirSync1  = dirIn;
    next_st.dirSync2  = st.dirSync1;
    if (st.trigSync2 == st.trigStable) begin
      next_st.trigCnt = '0;
    end else if (st.trigCnt >= 16'(DEBOUNCE_CYC - 1)) begin
      next_st.trigCnt    = '0;
      next_st.trigStable = st.trigSync2;
    end else begin
      next_st.trigCnt = st.trigCnt + 16'h0001;
    end
    if (st.dirSync2 == st.dirStable) begin
      next_st.dirCnt = '0;
    end else if (st.dirCnt >= 16'(DEBOUNCE_CYC - 1)) begin
      next_st.dirCnt    = '0;
      next_st.dirStable = st.dirSync2;
    end else begin
      next_st.dirCnt = st.dirCnt + 16'h0001;
    end
    trigFall = st.trigStable && !next_st.trigStable;
    trigRise = !st.trigStable && next_st.trigStable;
    dirFall  = st.dirStable && !next_st.dirStable;
    dirRise  = !st.dirStable && next_st.dirStable;

    // Trigger decode
    unique case (ptc_pkg::ptc_trig_e'(st.trig))
      ptc_pkg::FALLING_TOGGLE:            toggleReq = trigFall;
      ptc_pkg::FALLING_START_RISING_STOP: begin
        startReq = trigFall;
        stopReq  = trigRise;
      end
      ptc_pkg::RISING_TOGGLE:             toggleReq = trigRise;
      ptc_pkg::LEVEL_FOLLOW: begin
        stopReq  = trigFall;
        startReq = trigRise;
      end
      ptc_pkg::FALLING_START_ONLY:        startReq = trigFall;
      ptc_pkg::RISING_START_ONLY:         startReq = trigRise;
      ptc_pkg::FALLING_STOP_ONLY:         stopReq  = trigFall;
      ptc_pkg::RISING_STOP_ONLY:          stopReq  = trigRise;
      ptc_pkg::RUN_ON_LOW:                startReq = !st.trigStable;
      ptc_pkg::RUN_ON_HIGH:               startReq = st.trigStable;
      ptc_pkg::HALT_ON_LOW:               stopReq  = !st.trigStable;
      ptc_pkg::HALT_ON_HIGH:              stopReq  = st.trigStable;
      ptc_pkg::TRIGGER_DISABLED:          ;
      ptc_pkg::EDGE_RAISES_EVENT: begin
        if (trigFall || trigRise) next_st.event_ = 1'b1;
      end
      ptc_pkg::KEY_RAISES_EVENT:          ;
      default:                            ;
    endcase

    keyEventMode = st.trig == 4'(ptc_pkg::KEY_RAISES_EVENT);
    if (keyStartStop && st.run && keyEventMode) begin
      next_st.event_ = 1'b1;
    end else if (keyStartStop) begin
      toggleReq = toggleReq ^ 1'b1;
    end
    if (wrCmd && regWrData[ptc_pkg::CMD_RUN])  startReq = 1'b1;
    if (wrCmd && regWrData[ptc_pkg::CMD_STOP]) stopReq  = 1'b1;
    // Event set wins over a same-cycle clear
    if (wrCmd && regWrData[ptc_pkg::CMD_CLR_EVENT] &&
        !(st.trig == 4'(ptc_pkg::EDGE_RAISES_EVENT) &&
          (trigFall || trigRise)) &&
        !(keyStartStop && st.run && keyEventMode)) begin
      next_st.event_ = 1'b0;
    end

    // Stop wins when start and stop collide
    if (stopReq) begin
      next_st.run = 1'b0;
    end else if (startReq) begin
      next_st.run = 1'b1;
    end else if (toggleReq) begin
      next_st.run = !st.run;
    end
    if (programEnded) next_st.run = 1'b0;

    // Program-only modes accepted only while running
    if (progTrigWrite && progTrigMode <= 4'(ptc_pkg::KEY_RAISES_EVENT) &&
        (st.run || progTrigMode < 4'(ptc_pkg::EDGE_RAISES_EVENT))) begin
      next_st.trig = progTrigMode;
    end

    if (dirFall) next_st.withdraw = st.dirTwin;
    if (dirRise) next_st.withdraw = !st.dirTwin;

    if (st.run && !next_st.run && st.comm == ptc_pkg::COMM_ALTERNATE) begin
      next_st.secStart = 1'b1;
    end

    // Alarm: steady tone until a key press silences it
    if (alarmCond && !st.alarmLatched) begin
      next_st.alarmLatched  = 1'b1;
      next_st.alarmSilenced = 1'b0;
    end else if (!alarmCond) begin
      next_st.alarmLatched = 1'b0;
    end
    if (keyPress && st.alarmLatched) next_st.alarmSilenced = 1'b1;

    // Beep timing: one shared counter for single and continuous
    if (keyPress && st.beepEn) begin
      next_st.beepSingle = 1'b1;
      next_st.beepCnt    = '0;
    end else if (st.beepCnt >= 32'(BEEP_CYC - 1)) begin
      next_st.beepCnt    = '0;
      next_st.beepSingle = 1'b0;
      next_st.beepPhase  = !st.beepPhase;
    end else begin
      next_st.beepCnt = st.beepCnt + 32'h0000_0001;
    end

    // Register writes; settings from the bus ignore lockout
    if (wrSetup) begin
      // Program-only modes cannot become the stored default
      if (regWrData[ptc_pkg::SETUP_TRIG_LSB +: 4] <
          4'(ptc_pkg::EDGE_RAISES_EVENT)) begin
        next_st.trig = regWrData[ptc_pkg::SETUP_TRIG_LSB +: 4];
      end
      next_st.dirTwin  = regWrData[ptc_pkg::SETUP_DIRTWIN];
      next_st.outCfg   = regWrData[ptc_pkg::SETUP_OUTCFG];
      next_st.alarmEn  = regWrData[ptc_pkg::SETUP_ALARM];
      next_st.beepEn   = regWrData[ptc_pkg::SETUP_BEEP];
      next_st.lockEn   = regWrData[ptc_pkg::SETUP_LOCK];
      next_st.lowNoise = regWrData[ptc_pkg::SETUP_LOWNOISE];
      next_st.comm     = ptc_pkg::ptc_comm_e'(
                           regWrData[ptc_pkg::SETUP_COMM_LSB +: 2]);
    end
    if (wrNet) begin
      if (regWrData[ptc_pkg::NET_ADDR_LSB +: 7] <= ptc_pkg::MAX_ADDR) begin
        next_st.addr = regWrData[ptc_pkg::NET_ADDR_LSB +: 7];
      end
      if (regWrData[ptc_pkg::NET_BAUD_LSB +: 3] <= 3'(ptc_pkg::BAUD_19200))
      begin
        next_st.baud = ptc_pkg::ptc_baud_e'(
                         regWrData[ptc_pkg::NET_BAUD_LSB +: 3]);
      end
    end

    next_st.rdData = 16'h0000;
    if (regRead) begin
      unique case (regAddr)
        ptc_pkg::REG_SETUP:   next_st.rdData = {4'h0, st.comm, st.lowNoise,
          st.lockEn, st.beepEn, st.alarmEn, st.outCfg, st.dirTwin, st.trig};
        ptc_pkg::REG_NET:     next_st.rdData = {5'h00, st.baud, 1'b0,
                                                st.addr};
        ptc_pkg::REG_STATUS:  next_st.rdData = {8'h00, st.trigStable,
          st.dirStable, !lockKeyPresent_n, st.alarmLatched, st.event_,
          st.withdraw, st.run, 1'b0};
        ptc_pkg::REG_PRGTRIG: next_st.rdData = {12'h000, st.trig};
        default:              next_st.rdData = 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st       <= '0;
      st.trig  <= 4'(ptc_pkg::RST_TRIG);
      st.addr  <= ptc_pkg::RST_ADDR;
      st.baud  <= ptc_pkg::RST_BAUD;
      st.comm  <= ptc_pkg::COMM_ADDRESS;
      st.trigStable <= 1'b1;
      st.trigSync1  <= 1'b1;
      st.trigSync2  <= 1'b1;
      st.dirStable  <= 1'b1;
      st.dirSync1   <= 1'b1;
      st.dirSync2   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign regRdData    = st.rdData;
  assign runProgram   = st.run;
  assign programEvent = st.event_;
  assign dirWithdraw  = st.withdraw;
  assign motorOperating = motorPumping ||
                          (st.outCfg && pauseTimer && st.run);
  // Key plug grounds the pin, so low means present
  assign keySettingAllowed = keySetting &&
                             (!st.lockEn || !lockKeyPresent_n);
  assign buzzer = (st.alarmEn && st.alarmLatched && !st.alarmSilenced) ||
                  (st.beepEn && st.beepSingle) ||
                  (st.beepEn && (programEnded || waitStartTrig) &&
                   st.beepPhase);
  assign secRun = (st.comm == ptc_pkg::COMM_OPPOSITE ||
                   st.comm == ptc_pkg::COMM_TWIN) && st.run;
  assign secWithdraw = (st.comm == ptc_pkg::COMM_OPPOSITE) ?
                       !st.withdraw : st.withdraw;
  assign secStartPulse = st.secStart;

endmodule

//--- tb/ptc_foot_switch.sv
// Foot switch model on the trigger and direction pins.
// Assumes the bench changes the wanted levels right after a clk edge.
`timescale 1ns/100ps
module ptc_foot_switch (
  input  wire logic clk,
  input  wire logic wantTrig,
  input  wire logic wantDir,
  output logic      trigIn,
  output logic      dirIn
);
  logic       held = 1'b1;
  logic [2:0] chatter = 3'h0;
  initial trigIn = 1'b1;
  initial dirIn = 1'b1;
  // Contacts bounce shorter than the settle window: one press, one event
  always @(posedge clk) begin
    if (wantTrig != held) begin
      held    <= wantTrig;
      chatter <= 3'h3;
    end else if (chatter != 3'h0) begin
      chatter <= chatter - 3'h1;
    end
    trigIn <= chatter[0] ? ~held : held;
    dirIn  <= wantDir;
  end
endmodule

//--- tb/ptc_trigger_config_chk.sv
// Assertions on the ports of the trigger and configuration block.
// Assumes setup is written only through the register port.
`timescale 1ns/100ps
module ptc_trigger_config_chk #(
  parameter int DEBOUNCE_CYC = 4,
  parameter int BEEP_CYC     = 8
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrite,
  input wire logic        lockKeyPresent_n,
  input wire logic        keyPress,
  input wire logic        motorPumping,
  input wire logic        pauseTimer,
  input wire logic        alarmCond,
  input wire logic        motorOperating,
  input wire logic        buzzer,
  input wire logic        keySettingAllowed,
  input wire logic        runProgram,
  input wire logic        dirWithdraw,
  input wire logic        secRun,
  input wire logic        secWithdraw,
  input wire logic        secStartPulse
);
  // Shadow of setup, so each property knows which mode applies
  logic [15:0] setup;
  logic [1:0]  comm;
  logic        outCfg;
  assign comm = setup[ptc_pkg::SETUP_COMM_LSB +: 2];
  assign outCfg = setup[ptc_pkg::SETUP_OUTCFG];
  always_ff @(posedge clk) begin
    if (!nrst) begin
      setup <= 16'h0000;
    end else if (regWrite && regAddr == ptc_pkg::REG_SETUP) begin
      setup <= regWrData;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////
  motor_idle_a: assert property (
    !outCfg |-> motorOperating == motorPumping)
    else $error("motor output differs from pumping");
  motor_pause_a: assert property (
    outCfg |-> motorOperating == (motorPumping | (pauseTimer & runProgram)))
    else $error("motor output wrong with pause setting");
  lock_keys_a: assert property (
    setup[ptc_pkg::SETUP_LOCK] && lockKeyPresent_n |-> !keySettingAllowed)
    else $error("setting change allowed without key");
  alarm_on_a: assert property (
    setup[ptc_pkg::SETUP_ALARM] && $rose(alarmCond) && !keyPress
      |-> ##[0:2] buzzer)
    else $error("alarm did not sound");
  fwd_reverse_a: assert property (
    comm == 2'h1 |-> secRun == runProgram && secWithdraw != dirWithdraw)
    else $error("secondary not reversed");
  fwd_same_a: assert property (
    comm == 2'h2 |-> secRun == runProgram && secWithdraw == dirWithdraw)
    else $error("secondary not following");
  alt_start_a: assert property (
    comm == 2'h3 && $fell(runProgram) |-> ##[0:1] secStartPulse)
    else $error("secondary not started on stop");
  start_pulse_a: assert property (
    secStartPulse |=> !secStartPulse)
    else $error("secondary start longer than a cycle");
endmodule

//--- tb/tb.sv
// Bench for the trigger block: register tasks and pin scenarios.
// Assumes reads answer one cycle after the strobe.
`timescale 1ns/100ps
module tb;
  localparam logic [3:0] MODES [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
    4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
  // Run after fall, rise: from stopped, then from running
  localparam logic [3:0] EXP [13] = '{4'hC, 4'hA, 4'h6, 4'h5, 4'hF,
    4'h7, 4'h0, 4'h2, 4'hF, 4'hF, 4'h0, 4'h0, 4'h3};
  logic        clk = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [3:0]  regAddr = 4'h0, progTrigMode = 4'h0;
  logic [15:0] regWrData = 16'h0000, regRdData;
  logic        trigIn, dirIn, wantTrig = 1'b1, wantDir = 1'b1;
  logic        lockKeyPresent_n = 1'b1, keyPress = 1'b0;
  logic        keyStartStop = 1'b0, keySetting = 1'b0;
  logic        motorPumping = 1'b0, pauseTimer = 1'b0;
  logic        programEnded = 1'b0, waitStartTrig = 1'b0;
  logic        alarmCond = 1'b0, progTrigWrite = 1'b0;
  logic        motorOperating, buzzer, keySettingAllowed, runProgram;
  logic        programEvent, dirWithdraw, secRun, secWithdraw;
  logic        secStartPulse, seen, last;
  int          n_mismatch = 0, n_checks = 0, flips;
  always #5 clk = ~clk;
  ptc_foot_switch u_ptc_foot_switch (.clk, .wantTrig, .wantDir, .trigIn,
    .dirIn);
  ptc_trigger_config #(.DEBOUNCE_CYC(4), .BEEP_CYC(8))
    u_ptc_trigger_config (.clk, .nrst, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .trigIn, .dirIn, .lockKeyPresent_n,
    .motorOperating, .buzzer, .keyPress, .keyStartStop, .keySetting,
    .keySettingAllowed, .motorPumping, .pauseTimer, .programEnded,
    .waitStartTrig, .alarmCond, .progTrigWrite, .progTrigMode,
    .runProgram, .programEvent, .dirWithdraw, .secRun, .secWithdraw,
    .secStartPulse);
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite  <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask
  // Pin moves pass chatter, sync and settle before the check
  task automatic pins(input logic t, input logic d);
    @(posedge clk);
    wantTrig <= t;
    wantDir  <= d;
    tick(20);
  endtask
  task automatic mode(input logic [3:0] m);
    @(posedge clk);
    progTrigWrite <= 1'b1;
    progTrigMode  <= m;
    @(posedge clk);
    progTrigWrite <= 1'b0;
  endtask
  task automatic key(input logic ss);
    @(posedge clk);
    keyPress     <= 1'b1;
    keyStartStop <= ss;
    @(posedge clk);
    keyPress     <= 1'b0;
    keyStartStop <= 1'b0;
    tick(2);
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // More than ten times the under two thousand cycles the sequence needs
  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(ptc_pkg::REG_NET, 16'h0400);
    rd(ptc_pkg::REG_PRGTRIG, 16'h0000);
    rd(ptc_pkg::REG_STATUS, 16'h00C0);
    rd(4'hF, 16'h0000);
    for (int b = 0; b < 5; b++) begin
      wr(ptc_pkg::REG_NET, {5'h00, b[2:0], 8'h63});
      rd(ptc_pkg::REG_NET, {5'h00, b[2:0], 8'h63});
    end
    wr(ptc_pkg::REG_NET, 16'h0464);
    rd(ptc_pkg::REG_NET, 16'h0463);
    wr(ptc_pkg::REG_NET, 16'h0563);
    rd(ptc_pkg::REG_NET, 16'h0463);
    for (int i = 0; i < 13; i++) begin
      for (int p = 0; p < 2; p++) begin
        mode(MODES[i]);
        wr(ptc_pkg::REG_CMD, p ? 16'h0001 : 16'h0002);
        pins(1'b0, 1'b1);
        chk(runProgram, EXP[i][3-2*p]);
        pins(1'b1, 1'b1);
        chk(runProgram, EXP[i][2-2*p]);
      end
    end
    wr(ptc_pkg::REG_CMD, 16'h0002);
    mode(4'hD);
    rd(ptc_pkg::REG_PRGTRIG, 16'h000C);
    wr(ptc_pkg::REG_CMD, 16'h0001);
    mode(4'hD);
    rd(ptc_pkg::REG_PRGTRIG, 16'h000D);
    pins(1'b0, 1'b1);
    chk(runProgram, 1'b1);
    chk(programEvent, 1'b1);
    pins(1'b1, 1'b1);
    wr(ptc_pkg::REG_CMD, 16'h0004);
    tick(1);
    chk(programEvent, 1'b0);
    mode(4'hE);
    key(1'b1);
    chk(runProgram, 1'b1);
    chk(programEvent, 1'b1);
    mode(4'hF);
    rd(ptc_pkg::REG_PRGTRIG, 16'h000E);
    mode(4'h0);
    key(1'b1);
    chk(runProgram, 1'b0);
    mode(4'hE);
    rd(ptc_pkg::REG_PRGTRIG, 16'h0000);
    wr(ptc_pkg::REG_CMD, 16'h0005);
    for (int t = 0; t < 2; t++) begin
      wr(ptc_pkg::REG_SETUP, t ? 16'h0810 : 16'h0400);
      pins(1'b1, 1'b0);
      chk(dirWithdraw, t[0]);
      chk(secWithdraw, 1'b1);
      pins(1'b1, 1'b1);
      chk(dirWithdraw, !t[0]);
      chk(secWithdraw, 1'b0);
      chk(secRun, 1'b1);
    end
    wr(ptc_pkg::REG_SETUP, 16'h0C00);
    wr(ptc_pkg::REG_CMD, 16'h0002);
    seen = 1'b0;
    repeat (3) begin
      #1 seen |= secStartPulse;
      @(posedge clk);
    end
    chk(seen, 1'b1);
    for (int k = 0; k < 16; k++) begin
      wr(ptc_pkg::REG_SETUP, k[3] ? 16'h0020 : 16'h0000);
      wr(ptc_pkg::REG_CMD, k[2] ? 16'h0001 : 16'h0002);
      @(posedge clk);
      motorPumping <= k[1];
      pauseTimer   <= k[0];
      tick(1);
      chk(motorOperating, k[1] | (k[3] & k[2] & k[0]));
    end
    wr(ptc_pkg::REG_SETUP, 16'h0100);
    keySetting <= 1'b1;
    tick(20);
    chk(keySettingAllowed, 1'b0);
    wr(ptc_pkg::REG_NET, 16'h0405);
    rd(ptc_pkg::REG_NET, 16'h0405);
    @(posedge clk);
    lockKeyPresent_n <= 1'b0;
    tick(20);
    chk(keySettingAllowed, 1'b1);
    wr(ptc_pkg::REG_SETUP, 16'h0040);
    alarmCond <= 1'b1;
    tick(13);
    chk(buzzer, 1'b1);
    key(1'b0);
    chk(buzzer, 1'b0);
    wr(ptc_pkg::REG_SETUP, 16'h0080);
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      programEnded  <= !c[0];
      waitStartTrig <= c[0];
      tick(1);
      last = buzzer;
      flips = 0;
      repeat (40) begin
        tick(1);
        flips += int'(buzzer !== last);
        last = buzzer;
      end
      chk(16'(flips >= 3), 16'h0001);
    end
    chk(runProgram, 1'b0);
    @(posedge clk);
    waitStartTrig <= 1'b0;
    key(1'b0);
    chk(buzzer, 1'b1);
    tick(8);
    chk(buzzer, 1'b0);
    end_of_test();
  end
endmodule

bind ptc_trigger_config ptc_trigger_config_chk #(
  .DEBOUNCE_CYC(DEBOUNCE_CYC), .BEEP_CYC(BEEP_CYC))
  u_ptc_trigger_config_chk (.clk, .nrst, .regAddr, .regWrData, .regWrite,
  .lockKeyPresent_n, .keyPress, .motorPumping, .pauseTimer, .alarmCond,
  .motorOperating, .buzzer, .keySettingAllowed, .runProgram, .dirWithdraw,
  .secRun, .secWithdraw, .secStartPulse);
